// *** opsc_map.svh ***
// Register offsets, field positions, reset values and counts of the oscillator and PLL control.
`ifndef OPSC_MAP_SVH
`define OPSC_MAP_SVH

// Word offsets on the register bus.
`define OPSC_MAIN_OSC_CTRL_OFS 8'h00
`define OPSC_MAIN_FREQ_OFS 8'h04
`define OPSC_PLL_A_CTRL_OFS 8'h08
`define OPSC_PLL_B_CTRL_OFS 8'h0C
`define OPSC_POWER_STATUS_OFS 8'h10
`define OPSC_IRQ_MASK_OFS 8'h14

// Fields of the main oscillator control register.
`define OPSC_MOR_EN_BIT 0
`define OPSC_MOR_BYP_BIT 1
`define OPSC_MOR_SEL_BIT 2
`define OPSC_MOR_CNT_LSB 8
`define OPSC_MOR_CNT_W 8

// Fields of the frequency register.
`define OPSC_MCF_CNT_LSB 0
`define OPSC_MCF_CNT_W 16
`define OPSC_MCF_DONE_BIT 16

// Fields of each PLL control register.
`define OPSC_PLL_DIV_LSB 0
`define OPSC_PLL_DIV_W 8
`define OPSC_PLL_CNT_LSB 8
`define OPSC_PLL_CNT_W 6
`define OPSC_PLL_MUL_LSB 16
`define OPSC_PLL_MUL_W 11

// Status and mask bit positions.
`define OPSC_ST_STABLE_BIT 0
`define OPSC_ST_LOCK_A_BIT 1
`define OPSC_ST_LOCK_B_BIT 2
`define OPSC_ST_W 3

// Reset values.
`define OPSC_MOR_RESET 32'h0000_0000
`define OPSC_PLL_RESET 32'h0000_0000
`define OPSC_MASK_RESET 3'h0

// Timing counts in slow-clock periods.
`define OPSC_OSC_PRESCALE 8
`define OPSC_FREQ_PERIODS 16

`endif

// *** opsc_pkg.sv ***
// Types shared by the oscillator and PLL control.
package opsc_pkg;
    `include "opsc_map.svh"

    // Settings of one divider-and-PLL block, as handed to the analog loop.
    typedef struct packed {
        logic [`OPSC_PLL_MUL_W-1:0] gain;
        logic [`OPSC_PLL_CNT_W-1:0] lock_count;
        logic [`OPSC_PLL_DIV_W-1:0] prescale;
    } opsc_pll_ctrl_t;

    // Phases of the main-clock frequency measurement.
    typedef enum logic [1:0] {
        FM_IDLE,
        FM_WAIT,
        FM_COUNT,
        FM_DONE
    } opsc_freq_state_t;
endpackage

// *** opsc_ctrl.sv ***
// Oscillator start-up, frequency measurement and PLL lock control behind an AHB-Lite slave.
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`include "opsc_map.svh"

// Notes on behaviour
// [R1] Reset: oscillator off, slow clock selected.
// [R2] Clearing enable clears stable flag immediately.
// [R3] Software loads start-up count covering crystal start.
// [R4] Enable write clears stable, counts down slow/8.
// [R5] Start-up count field is eight bits.
// [R6] Count zero sets stable; maskable interrupt.
// [R7] Measurement starts at next slow rising edge.
// [R8] Sixteenth slow falling edge stops, sets done.
// [R9] External clock: software sets bypass, clears enable.
// [R10] Divider accepts every ratio 1 to 255.
// [R11] Ratio zero holds divider and PLL high.
// [R12] Every prescale ratio resets to zero.
// [R13] Output frequency is source times (gain+1)/ratio.
// [R14] Gain zero disables PLL; nonzero re-enables.
// [R15] Parameter write clears lock, reloads lock counter.
// [R16] Lock counter counts slow cycles, sets lock.
// [R17] Software programs lock count covering settling.
// [R18] Two independent PLL outputs, A and B.
// [R19] Software writes bit 29 set in PLL A.
// [R20] Masked stable and lock flags form one request.
module opsc_ctrl
    import opsc_pkg::*;
#(
    parameter int CNT_W = `OPSC_MOR_CNT_W,
    parameter int FREQ_W = `OPSC_MCF_CNT_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic low_rate_clock,
    input wire logic main_osc_clock,
    output logic main_osc_enable,
    output logic osc_bypass_a,
    output logic main_clock_select,
    output opsc_pll_ctrl_t pll_a_setting,
    output opsc_pll_ctrl_t pll_b_setting,
    output logic pll_a_clock,
    output logic pll_b_clock,
    output logic irq
);

    // The start-up count must fit its register field and the frequency count its word.
    if (CNT_W != `OPSC_MOR_CNT_W || FREQ_W < 8 || FREQ_W > 16) begin : g_bad_param
        $error("opsc_ctrl: unsupported CNT_W or FREQ_W");
    end

    // Bus bookkeeping.
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic addr_phase;
    logic wr_now;

    // Oscillator state.
    logic osc_en_ff;
    logic osc_byp_ff;
    logic main_sel_ff;
    logic [CNT_W-1:0] osc_cnt_load_ff;
    logic [CNT_W-1:0] osc_cnt_ff;
    logic [2:0] osc_pre_ff;
    logic osc_run_ff;
    logic osc_stable_ff;

    // Slow and main clock edge detection.
    logic slow_q_ff;
    logic main_q_ff;
    logic slow_rise;
    logic slow_fall;
    logic main_rise;

    // Frequency measurement.
    opsc_freq_state_t fm_state_ff;
    logic [FREQ_W-1:0] freq_cnt_ff;
    logic [4:0] fall_cnt_ff;

    // Per-PLL state.
    opsc_pll_ctrl_t pll_ctrl_ff [2];
    logic [`OPSC_PLL_CNT_W-1:0] lock_cnt_ff [2];
    logic locked_ff [2];
    logic [`OPSC_PLL_DIV_W-1:0] div_cnt_ff [2];
    logic pll_clk_ff [2];
    logic pll_wr [2];

    logic [`OPSC_ST_W-1:0] mask_ff;
    logic [`OPSC_ST_W-1:0] status;
    logic [31:0] rd_mux;

    // The slave never inserts wait states, so a transfer finishes in its first data cycle.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign addr_phase = hsel && hready && htrans[1];
    assign wr_now = wr_pend_ff;

    // Inputs arrive synchronous to hclk, so one stage is enough to see their edges.
    assign slow_rise = low_rate_clock && !slow_q_ff;
    assign slow_fall = !low_rate_clock && slow_q_ff;
    assign main_rise = main_osc_clock && !main_q_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_q_ff <= 1'b0;
            main_q_ff <= 1'b0;
        end else begin
            slow_q_ff <= low_rate_clock;
            main_q_ff <= main_osc_clock;
        end
    end

    // Write address is held for the data phase; read data is fetched in the address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_ff <= {haddr[7:2], 2'b00};
            end
            if (addr_phase && !hwrite) begin
                hrdata_ff <= rd_mux;
            end
        end
    end

    assign status = {locked_ff[1], locked_ff[0], osc_stable_ff};

    // Read mux; unmapped words read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case ({haddr[7:2], 2'b00})
            `OPSC_MAIN_OSC_CTRL_OFS: begin
                rd_mux[`OPSC_MOR_EN_BIT] = osc_en_ff;
                rd_mux[`OPSC_MOR_BYP_BIT] = osc_byp_ff;
                rd_mux[`OPSC_MOR_SEL_BIT] = main_sel_ff;
                rd_mux[`OPSC_MOR_CNT_LSB +: CNT_W] = osc_cnt_load_ff; // [R5]
            end
            `OPSC_MAIN_FREQ_OFS: begin
                rd_mux[`OPSC_MCF_CNT_LSB +: FREQ_W] = freq_cnt_ff;
                rd_mux[`OPSC_MCF_DONE_BIT] = (fm_state_ff == FM_DONE);
            end
            `OPSC_PLL_A_CTRL_OFS: begin
                rd_mux[`OPSC_PLL_DIV_LSB +: `OPSC_PLL_DIV_W] = pll_ctrl_ff[0].prescale;
                rd_mux[`OPSC_PLL_CNT_LSB +: `OPSC_PLL_CNT_W] = pll_ctrl_ff[0].lock_count;
                rd_mux[`OPSC_PLL_MUL_LSB +: `OPSC_PLL_MUL_W] = pll_ctrl_ff[0].gain;
            end
            `OPSC_PLL_B_CTRL_OFS: begin
                rd_mux[`OPSC_PLL_DIV_LSB +: `OPSC_PLL_DIV_W] = pll_ctrl_ff[1].prescale;
                rd_mux[`OPSC_PLL_CNT_LSB +: `OPSC_PLL_CNT_W] = pll_ctrl_ff[1].lock_count;
                rd_mux[`OPSC_PLL_MUL_LSB +: `OPSC_PLL_MUL_W] = pll_ctrl_ff[1].gain;
            end
            `OPSC_POWER_STATUS_OFS: begin
                rd_mux[`OPSC_ST_W-1:0] = status;
            end
            `OPSC_IRQ_MASK_OFS: begin
                rd_mux[`OPSC_ST_W-1:0] = mask_ff;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Oscillator control fields; reset leaves the oscillator off and the slow clock in use.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_en_ff <= 1'(`OPSC_MOR_RESET >> `OPSC_MOR_EN_BIT); // [R1]
            osc_byp_ff <= 1'b0;
            main_sel_ff <= 1'b0; // [R1]
            osc_cnt_load_ff <= '0;
            mask_ff <= `OPSC_MASK_RESET;
        end else begin
            if (wr_now && wr_addr_ff == `OPSC_MAIN_OSC_CTRL_OFS) begin
                osc_en_ff <= hwdata[`OPSC_MOR_EN_BIT];
                osc_byp_ff <= hwdata[`OPSC_MOR_BYP_BIT];
                main_sel_ff <= hwdata[`OPSC_MOR_SEL_BIT];
                osc_cnt_load_ff <= hwdata[`OPSC_MOR_CNT_LSB +: CNT_W]; // [R5]
            end
            if (wr_now && wr_addr_ff == `OPSC_IRQ_MASK_OFS) begin
                mask_ff <= hwdata[`OPSC_ST_W-1:0];
            end
        end
    end

    // Start-up countdown, one step per eight slow-clock periods.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_cnt_ff <= '0;
            osc_pre_ff <= 3'h0;
            osc_run_ff <= 1'b0;
            osc_stable_ff <= 1'b0;
        end else if (wr_now && wr_addr_ff == `OPSC_MAIN_OSC_CTRL_OFS) begin
            // Any write restarts the wait; a write with enable low just turns it off.
            osc_cnt_ff <= hwdata[`OPSC_MOR_CNT_LSB +: CNT_W]; // [R4]
            osc_pre_ff <= 3'h0;
            osc_run_ff <= hwdata[`OPSC_MOR_EN_BIT]; // [R4]
            osc_stable_ff <= 1'b0; // [R2] [R4]
        end else if (osc_run_ff && slow_rise) begin
            osc_pre_ff <= osc_pre_ff + 3'h1;
            if (osc_pre_ff == 3'(`OPSC_OSC_PRESCALE - 1)) begin // [R4]
                if (osc_cnt_ff <= CNT_W'(1)) begin
                    osc_cnt_ff <= '0;
                    osc_run_ff <= 1'b0;
                    osc_stable_ff <= 1'b1; // [R6]
                end else begin
                    osc_cnt_ff <= osc_cnt_ff - CNT_W'(1);
                end
            end
        end
    end

    // Frequency measurement: wait a slow rising edge, count to the sixteenth falling edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fm_state_ff <= FM_IDLE;
            freq_cnt_ff <= '0;
            fall_cnt_ff <= 5'h00;
        end else if (!osc_stable_ff) begin
            fm_state_ff <= FM_IDLE;
        end else begin
            case (fm_state_ff)
                FM_IDLE: begin
                    freq_cnt_ff <= '0;
                    fall_cnt_ff <= 5'h00;
                    fm_state_ff <= FM_WAIT;
                end
                FM_WAIT: begin
                    if (slow_rise) begin
                        fm_state_ff <= FM_COUNT; // [R7]
                    end
                end
                FM_COUNT: begin
                    if (main_rise) begin
                        freq_cnt_ff <= freq_cnt_ff + FREQ_W'(1); // [R7]
                    end
                    if (slow_fall) begin
                        fall_cnt_ff <= fall_cnt_ff + 5'h01;
                        if (fall_cnt_ff == 5'(`OPSC_FREQ_PERIODS - 1)) begin
                            fm_state_ff <= FM_DONE; // [R8]
                        end
                    end
                end
                FM_DONE: begin
                    fm_state_ff <= FM_DONE; // [R8]
                end
                default: begin
                    fm_state_ff <= FM_IDLE;
                end
            endcase
        end
    end

    // Two identical divider-and-PLL blocks, each with its own lock counter.
    for (genvar p = 0; p < 2; p++) begin : g_pll // [R18]
        assign pll_wr[p] = wr_now && (wr_addr_ff == ((p == 0) ? `OPSC_PLL_A_CTRL_OFS
                                                              : `OPSC_PLL_B_CTRL_OFS));

        // Settings register; the prescale ratio resets to zero so no input clock runs.
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pll_ctrl_ff[p] <= opsc_pll_ctrl_t'(`OPSC_PLL_RESET); // [R12]
            end else if (pll_wr[p]) begin
                pll_ctrl_ff[p].prescale <= hwdata[`OPSC_PLL_DIV_LSB +: `OPSC_PLL_DIV_W];
                pll_ctrl_ff[p].lock_count <= hwdata[`OPSC_PLL_CNT_LSB +: `OPSC_PLL_CNT_W];
                pll_ctrl_ff[p].gain <= hwdata[`OPSC_PLL_MUL_LSB +: `OPSC_PLL_MUL_W]; // [R14]
            end
        end

        // Lock counter; a disabled loop never reports lock.
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                lock_cnt_ff[p] <= '0;
                locked_ff[p] <= 1'b0;
            end else if (pll_wr[p]) begin
                lock_cnt_ff[p] <= hwdata[`OPSC_PLL_CNT_LSB +: `OPSC_PLL_CNT_W]; // [R15]
                locked_ff[p] <= 1'b0; // [R15]
            end else if (pll_ctrl_ff[p].gain == '0) begin
                locked_ff[p] <= 1'b0; // [R14]
            end else if (!locked_ff[p] && slow_rise) begin
                if (lock_cnt_ff[p] <= `OPSC_PLL_CNT_W'(1)) begin
                    lock_cnt_ff[p] <= '0;
                    locked_ff[p] <= 1'b1; // [R16]
                end else begin
                    lock_cnt_ff[p] <= lock_cnt_ff[p] - `OPSC_PLL_CNT_W'(1); // [R16]
                end
            end
        end

        // Input divider from the main clock; the multiply itself is done by the analog loop.
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                div_cnt_ff[p] <= '0;
                pll_clk_ff[p] <= 1'b1; // [R11]
            end else if (pll_ctrl_ff[p].prescale == '0) begin
                div_cnt_ff[p] <= '0;
                pll_clk_ff[p] <= 1'b1; // [R11]
            end else if (pll_ctrl_ff[p].gain == '0) begin
                div_cnt_ff[p] <= '0;
                pll_clk_ff[p] <= 1'b0; // [R14]
            end else if (pll_ctrl_ff[p].prescale == `OPSC_PLL_DIV_W'(1)) begin
                pll_clk_ff[p] <= main_osc_clock; // [R10]
            end else if (main_rise) begin
                // Wraps at the programmed ratio, so every value 2 to 255 divides exactly.
                if (div_cnt_ff[p] >= pll_ctrl_ff[p].prescale - `OPSC_PLL_DIV_W'(1)) begin
                    div_cnt_ff[p] <= '0; // [R10]
                    pll_clk_ff[p] <= 1'b1;
                end else begin
                    div_cnt_ff[p] <= div_cnt_ff[p] + `OPSC_PLL_DIV_W'(1);
                    pll_clk_ff[p] <= (div_cnt_ff[p] + `OPSC_PLL_DIV_W'(1))
                                     < (pll_ctrl_ff[p].prescale >> 1);
                end
            end
        end
    end

    // Settings go to the analog loops, which scale the divided clock by gain plus one.
    assign pll_a_setting = pll_ctrl_ff[0]; // [R13]
    assign pll_b_setting = pll_ctrl_ff[1]; // [R13]
    assign pll_a_clock = pll_clk_ff[0];
    assign pll_b_clock = pll_clk_ff[1];

    assign main_osc_enable = osc_en_ff; // [R1]
    assign osc_bypass_a = osc_byp_ff;
    // Switching to the main clock before it is stable would feed a dead clock downstream.
    assign main_clock_select = main_sel_ff && osc_stable_ff;

    // Level request: it follows the flags and drops as soon as no flag is set with its mask bit set.
    assign irq = |(status & mask_ff); // [R6] [R16] [R20]

endmodule

// *** opsc_ctrl_properties.sv ***
// Concurrent checks on the ports of the oscillator and PLL control.
`timescale 1ns/10ps
`include "opsc_map.svh"
module opsc_ctrl_properties
    import opsc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic main_osc_enable,
    input wire logic osc_bypass_a,
    input wire logic main_clock_select,
    input wire opsc_pll_ctrl_t pll_a_setting,
    input wire opsc_pll_ctrl_t pll_b_setting,
    input wire logic pll_a_clock
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // The PLL fields as a write would place them, packed like the settings struct.
    wire logic [24:0] wr_pll = {hwdata[26:16], hwdata[13:8], hwdata[7:0]};
    wire logic take = hsel && hready && htrans[1] && hwrite;
    wire logic [5:0] widx = haddr[7:2];
    logic [1:0] wsel_ff;

    // Tracks the register written in the data phase: 1 oscillator, 2 PLL A, 3 PLL B.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wsel_ff <= 2'h0;
        end else if (!take) begin
            wsel_ff <= 2'h0;
        end else begin
            wsel_ff <= (widx == 6'h00) ? 2'h1 : (widx == 6'h02) ? 2'h2 :
                       (widx == 6'h03) ? 2'h3 : 2'h0;
        end
    end

    a_select_needs_enable: assert property (main_clock_select |-> main_osc_enable)
        else $error("main clock selected while oscillator off");
    a_enable_from_write: assert property (wsel_ff == 2'h1 |=> main_osc_enable == $past(hwdata[0]))
        else $error("oscillator enable does not follow the write");
    a_write_drops_select: assert property (wsel_ff == 2'h1 |=> !main_clock_select)
        else $error("main clock still selected after a restart");
    a_bypass_from_write: assert property (wsel_ff == 2'h1 |=> osc_bypass_a == $past(hwdata[1]))
        else $error("bypass does not follow the write");
    a_pll_a_load: assert property (wsel_ff == 2'h2 |=> pll_a_setting == $past(wr_pll))
        else $error("PLL A settings differ from the write");
    a_pll_b_load: assert property (wsel_ff == 2'h3 |=> pll_b_setting == $past(wr_pll))
        else $error("PLL B settings differ from the write");
    a_pll_a_kept: assert property (wsel_ff != 2'h2 |=> $stable(pll_a_setting))
        else $error("PLL A settings changed without a write");
    a_ratio_zero_high: assert property (pll_a_setting.prescale == 8'h00 &&
        $past(pll_a_setting.prescale) == 8'h00 |-> pll_a_clock)
        else $error("PLL A output not high with ratio zero");
    a_gain_zero_low: assert property (pll_a_setting.prescale != 8'h00 &&
        pll_a_setting.gain == 11'h000 && $stable(pll_a_setting) |-> !pll_a_clock)
        else $error("PLL A output running with gain zero");

    // Main scenarios reached by the bench.
    c_osc_start: cover property (wsel_ff == 2'h1 && hwdata[0]);
    c_pll_b_write: cover property (wsel_ff == 2'h3);
    c_pll_a_toggle: cover property ($fell(pll_a_clock));
endmodule

bind opsc_ctrl opsc_ctrl_properties opsc_ctrl_properties_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .main_osc_enable(main_osc_enable), .osc_bypass_a(osc_bypass_a),
    .main_clock_select(main_clock_select), .pll_a_setting(pll_a_setting),
    .pll_b_setting(pll_b_setting), .pll_a_clock(pll_a_clock));

// *** opsc_tb.sv ***
// Self-checking bench for the oscillator and PLL control.
`timescale 1ns/10ps
`include "opsc_map.svh"
module testbench;
    import opsc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic low_rate_clock, main_osc_clock, main_osc_enable, osc_bypass_a, main_clock_select;
    logic pll_a_clock, pll_b_clock;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    opsc_pll_ctrl_t pll_a_setting, pll_b_setting;
    int err_total = 0, total_checks = 0, cycles = 0, slow_rises = 0, div_cnt = 0, s;
    assign hready = hreadyout;

    opsc_ctrl opsc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .low_rate_clock(low_rate_clock),
        .main_osc_clock(main_osc_clock), .main_osc_enable(main_osc_enable),
        .osc_bypass_a(osc_bypass_a), .main_clock_select(main_clock_select),
        .pll_a_setting(pll_a_setting), .pll_b_setting(pll_b_setting),
        .pll_a_clock(pll_a_clock), .pll_b_clock(pll_b_clock), .irq(irq));

    // Bus clock of 40 ns.
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // Slow clock of 20 bus cycles, main clock of 4; the design samples both on hclk.
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        div_cnt <= (div_cnt == 9) ? 0 : div_cnt + 1;
        if (div_cnt == 9) begin
            low_rate_clock <= !low_rate_clock;
            slow_rises <= slow_rises + int'(!low_rate_clock);
        end
        if (cycles % 2 == 1) main_osc_clock <= !main_osc_clock;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A measured count may land one edge either way of its ideal value.
    task automatic check_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_total++;
            $display("ERROR %0t: got %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // One single AHB-Lite transfer; read data lands in rd.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
        // Let the updates of this edge settle before the caller looks at outputs.
        #1;
    endtask

    task automatic poll(input logic [31:0] a, input int b);
        rd = 32'h0;
        for (int n = 0; n < 400 && rd[b] !== 1'b1; n++) bus(1'b0, a, 32'h0);
    endtask

    task automatic test_reset;
        check(main_osc_enable, 0);
        check(main_clock_select, 0);
        check(pll_a_setting | pll_b_setting, 0);
        check({pll_b_clock, pll_a_clock}, 2'b11);
        check({hreadyout, hresp}, 2'b10);
        bus(1'b0, `OPSC_MAIN_OSC_CTRL_OFS, 32'h0);
        check(rd, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic test_osc;
        bus(1'b1, `OPSC_IRQ_MASK_OFS, 32'h0000_0001);
        s = slow_rises;
        bus(1'b1, `OPSC_MAIN_OSC_CTRL_OFS, 32'h0000_0205);
        check(main_osc_enable, 1);
        poll(`OPSC_POWER_STATUS_OFS, 0);
        check_in(slow_rises - s, 15, 17);
        check(irq, 1);
        check(main_clock_select, 1);
        poll(`OPSC_MAIN_FREQ_OFS, 16);
        // From the start rise to the sixteenth fall is 15.5 slow periods of 5 main cycles.
        check_in(rd[15:0], 77, 78);
        bus(1'b1, `OPSC_MAIN_OSC_CTRL_OFS, 32'h0000_0200);
        bus(1'b0, `OPSC_POWER_STATUS_OFS, 32'h0);
        check(rd[0], 0);
        check(irq, 0);
        bus(1'b1, `OPSC_MAIN_OSC_CTRL_OFS, 32'h0000_FF02);
        bus(1'b0, `OPSC_MAIN_OSC_CTRL_OFS, 32'h0);
        check(rd, 32'h0000_FF02);
        check({main_osc_enable, osc_bypass_a}, 2'b01);
        $display("test osc done");
    endtask

    task automatic test_pll;
        logic last_b;
        bus(1'b1, `OPSC_IRQ_MASK_OFS, 32'h0000_0002);
        bus(1'b1, `OPSC_PLL_A_CTRL_OFS, 32'h2005_0302);
        s = slow_rises;
        check(pll_a_setting, {11'd5, 6'd3, 8'd2});
        bus(1'b0, `OPSC_POWER_STATUS_OFS, 32'h0);
        check(rd[1], 0);
        poll(`OPSC_POWER_STATUS_OFS, 1);
        check_in(slow_rises - s, 2, 4);
        check(irq, 1);
        bus(1'b1, `OPSC_PLL_A_CTRL_OFS, 32'h0001_01FF);
        check(pll_a_setting.prescale, 8'hFF);
        bus(1'b1, `OPSC_PLL_A_CTRL_OFS, 32'h0000_0102);
        repeat (100) @(posedge hclk);
        bus(1'b0, `OPSC_POWER_STATUS_OFS, 32'h0);
        check({rd[1], pll_a_clock, irq}, 3'b000);
        bus(1'b1, `OPSC_PLL_A_CTRL_OFS, 32'h0005_0100);
        repeat (10) @(posedge hclk);
        check(pll_a_clock, 1);
        bus(1'b1, `OPSC_PLL_B_CTRL_OFS, 32'h0003_0104);
        check(pll_b_setting, {11'd3, 6'd1, 8'd4});
        check(pll_a_setting, {11'd5, 6'd1, 8'd0});
        // Ratio four on a main clock of 4 bus cycles gives one rise every 16 bus cycles.
        s = 0;
        last_b = pll_b_clock;
        repeat (160) begin
            @(posedge hclk);
            s += int'(pll_b_clock && !last_b);
            last_b = pll_b_clock;
        end
        check_in(s, 9, 11);
        bus(1'b0, 32'h0000_0018, 32'h0);
        check(rd, 32'h0000_0000);
        $display("test pll done");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Reset for two cycles, then the scenarios in turn.
    initial begin
        {hresetn, hsel, hwrite, low_rate_clock, main_osc_clock} = 5'b0;
        {haddr, hwdata, htrans} = 66'h0;
        hsize = 3'b010;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset();
        test_osc();
        test_pll();
        final_report();
    end
endmodule
